// ===== design/spc_pkg.sv
`default_nettype none
package spc_pkg;

    // Command opcodes
    localparam logic [7:0] OP_SOFT_RESET = 8'hb0;
    localparam logic [7:0] OP_CLR_FAULT = 8'h8a;
    localparam logic [7:0] OP_MAX_SPEED = 8'he6;
    localparam logic [7:0] OP_START_SPEED = 8'he5;
    localparam logic [7:0] OP_MAX_ACCEL = 8'hea;
    localparam logic [7:0] OP_MAX_DECEL = 8'he9;
    localparam logic [7:0] OP_STEP_MODE = 8'h94;
    localparam logic [7:0] OP_REINIT = 8'h10;

    // Limits
    localparam logic [31:0] SPEED_MAX = 32'h1dcd6500;
    localparam logic [31:0] ACCEL_MIN = 32'h00000064;
    localparam logic [31:0] ACCEL_MAX = 32'h7fffffff;
    localparam logic [6:0] STEP_MODE_MAX = 7'h05;

    // Register offsets (byte addresses)
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_IRQ_STAT = 8'h08;
    localparam logic [7:0] A_IRQ_MASK = 8'h0c;
    localparam logic [7:0] A_MAX_SPEED = 8'h10;
    localparam logic [7:0] A_START_SPEED = 8'h14;
    localparam logic [7:0] A_MAX_ACCEL = 8'h18;
    localparam logic [7:0] A_MAX_DECEL = 8'h1c;
    localparam logic [7:0] A_STEP_MODE = 8'h20;
    localparam logic [7:0] A_ERRORS = 8'h24;
    localparam logic [7:0] A_POSITION = 8'h28;

    // Control bits
    localparam int CTRL_AUTO_CLR = 0;
    localparam int CTRL_SAFE_EN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    // Interrupt event bits
    localparam int EV_SOFT_RESET = 0;
    localparam int EV_FAULT_CLR = 1;
    localparam int EV_PARAM = 2;
    localparam int EV_BAD_CMD = 3;
    localparam int EV_W = 4;

    // Error bits
    localparam int ERR_DEENERGIZED = 0;
    localparam int ERR_SERIAL = 1;
    localparam int ERR_TIMEOUT = 2;

    typedef enum logic [1:0] {SPC_OP_RESET, SPC_OP_RUN} spc_op_t;

    // Working parameter set
    typedef struct packed {
        logic [31:0] max_speed;
        logic [31:0] start_speed;
        logic [31:0] max_accel;
        logic [31:0] max_decel;
        logic [6:0] step_mode;
    } spc_params_t;

    // One decoded command
    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [31:0] data;
    } spc_cmd_t;

endpackage
`default_nettype wire

// ===== design/spc_cmd_handler.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - Soft reset reloads settings, drops overrides
// - Soft reset halts motor, resets driver, state
// - Soft reset clears last move and positions
// - Soft reset clears serial, timeout, occurred errors
// - Soft reset enters safe start if enabled
// - Soft reset keeps de-energised error bit
// - Soft reset keeps uptime
// - Clear-fault command clears latched driver fault
// - Auto clearing clears faults without command
// - Max speed capped at 500,000,000
// - Overrides last until reset or reinit
// - Starting speed set, capped at 500,000,000
// - Acceleration below 100 becomes 100
// - Acceleration write leaves deceleration alone
// - Deceleration 0 copies accel, 1-99 become 100
// - Step mode codes 0 to 5 selected
module spc_cmd_handler (
    input wire logic mclk,
    input wire logic rst,
    input wire spc_pkg::spc_cmd_t cmd,
    input wire spc_pkg::spc_params_t nv_params,
    input wire logic driver_fault,
    input wire logic fault_set_deenergize,
    input wire logic fault_clr_deenergize,
    input wire logic err_serial_evt,
    input wire logic err_timeout_evt,
    input wire logic [7:0] err_occurred_evt,
    input wire logic pos_step,
    input wire logic pos_dir,
    input wire logic enc_step,
    input wire logic enc_dir,
    input wire logic move_cmd_valid,
    input wire logic [7:0] move_cmd,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output spc_pkg::spc_params_t work_params,
    output logic motor_halt,
    output logic driver_reset,
    output logic fault_clear,
    output logic safe_start,
    output spc_pkg::spc_op_t op_state,
    output logic [7:0] last_move,
    output logic [31:0] position,
    output logic [31:0] enc_position,
    output logic [2:0] err_flags,
    output logic [7:0] errors_occurred,
    output logic [31:0] uptime,
    output logic irq
);

    logic [1:0] ctrl;
    logic [spc_pkg::EV_W-1:0] irq_stat;
    logic [spc_pkg::EV_W-1:0] irq_mask;
    logic [spc_pkg::EV_W-1:0] events;
    logic soft_rst;
    logic reload;
    logic known;
    logic [31:0] next_accel;
    logic [31:0] next_decel;
    logic [31:0] next_speed;
    logic [31:0] next_start;

    // Command decode
    assign soft_rst = cmd.valid && cmd.opcode == spc_pkg::OP_SOFT_RESET;
    assign reload = soft_rst
        || (cmd.valid && cmd.opcode == spc_pkg::OP_REINIT);

    always_comb begin
        case (cmd.opcode)
            spc_pkg::OP_SOFT_RESET, spc_pkg::OP_CLR_FAULT,
            spc_pkg::OP_MAX_SPEED, spc_pkg::OP_START_SPEED,
            spc_pkg::OP_MAX_ACCEL, spc_pkg::OP_MAX_DECEL,
            spc_pkg::OP_STEP_MODE, spc_pkg::OP_REINIT: known = 1'b1;
            default: known = 1'b0;
        endcase
    end

    // Clamp incoming values before storing
    always_comb begin
        next_speed = (cmd.data > spc_pkg::SPEED_MAX) ?
            spc_pkg::SPEED_MAX : cmd.data;
        next_start = (cmd.data > spc_pkg::SPEED_MAX) ?
            spc_pkg::SPEED_MAX : cmd.data;
        if (cmd.data > spc_pkg::ACCEL_MAX) begin
            next_accel = spc_pkg::ACCEL_MAX;
        end else if (cmd.data < spc_pkg::ACCEL_MIN) begin
            next_accel = spc_pkg::ACCEL_MIN;
        end else begin
            next_accel = cmd.data;
        end
        if (cmd.data == 32'h00000000) begin
            next_decel = work_params.max_accel;
        end else if (cmd.data > spc_pkg::ACCEL_MAX) begin
            next_decel = spc_pkg::ACCEL_MAX;
        end else if (cmd.data < spc_pkg::ACCEL_MIN) begin
            next_decel = spc_pkg::ACCEL_MIN;
        end else begin
            next_decel = cmd.data;
        end
    end

    // Working copies; motion logic sees only these
    always_ff @(posedge mclk) begin
        if (rst || reload) begin
            work_params <= nv_params;
        end else if (cmd.valid) begin
            case (cmd.opcode)
                spc_pkg::OP_MAX_SPEED: work_params.max_speed <= next_speed;
                spc_pkg::OP_START_SPEED: begin
                    work_params.start_speed <= next_start;
                end
                spc_pkg::OP_MAX_ACCEL: begin
                    work_params.max_accel <= next_accel;
                end
                spc_pkg::OP_MAX_DECEL: work_params.max_decel <= next_decel;
                spc_pkg::OP_STEP_MODE: begin
                    // Out of range codes are ignored, mode stays put
                    if (cmd.data[6:0] <= spc_pkg::STEP_MODE_MAX) begin
                        work_params.step_mode <= cmd.data[6:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Halt, driver reset and operation state
    always_ff @(posedge mclk) begin
        if (rst) begin
            motor_halt <= 1'b0;
            driver_reset <= 1'b0;
            op_state <= spc_pkg::SPC_OP_RESET;
        end else begin
            motor_halt <= soft_rst;
            driver_reset <= soft_rst;
            if (soft_rst) begin
                op_state <= spc_pkg::SPC_OP_RESET;
            end else begin
                op_state <= spc_pkg::SPC_OP_RUN;
            end
        end
    end

    // Driver fault clearing: by command or automatically
    always_ff @(posedge mclk) begin
        if (rst) begin
            fault_clear <= 1'b0;
        end else begin
            fault_clear <= (cmd.valid && cmd.opcode == spc_pkg::OP_CLR_FAULT)
                || (driver_fault && ctrl[spc_pkg::CTRL_AUTO_CLR]);
        end
    end

    // Safe start; a later move command releases it
    always_ff @(posedge mclk) begin
        if (rst) begin
            safe_start <= 1'b0;
        end else if (soft_rst) begin
            safe_start <= ctrl[spc_pkg::CTRL_SAFE_EN];
        end else if (move_cmd_valid) begin
            safe_start <= 1'b0;
        end
    end

    // Last movement command
    always_ff @(posedge mclk) begin
        if (rst || soft_rst) begin
            last_move <= 8'h00;
        end else if (move_cmd_valid) begin
            last_move <= move_cmd;
        end
    end

    // Position counters
    always_ff @(posedge mclk) begin
        if (rst || soft_rst) begin
            position <= 32'h00000000;
            enc_position <= 32'h00000000;
        end else begin
            if (pos_step) begin
                position <= pos_dir ? position - 32'h1 : position + 32'h1;
            end
            if (enc_step) begin
                enc_position <= enc_dir ? enc_position - 32'h1
                                        : enc_position + 32'h1;
            end
        end
    end

    // Error flags; the de-energised bit survives soft reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            err_flags <= 3'h0;
        end else begin
            if (fault_set_deenergize) begin
                err_flags[spc_pkg::ERR_DEENERGIZED] <= 1'b1;
            end else if (fault_clr_deenergize) begin
                err_flags[spc_pkg::ERR_DEENERGIZED] <= 1'b0;
            end
            if (soft_rst) begin
                err_flags[spc_pkg::ERR_SERIAL] <= 1'b0;
                err_flags[spc_pkg::ERR_TIMEOUT] <= 1'b0;
            end else begin
                if (err_serial_evt) begin
                    err_flags[spc_pkg::ERR_SERIAL] <= 1'b1;
                end
                if (err_timeout_evt) begin
                    err_flags[spc_pkg::ERR_TIMEOUT] <= 1'b1;
                end
            end
        end
    end

    // Accumulated errors; soft reset clears them all
    always_ff @(posedge mclk) begin
        if (rst || soft_rst) begin
            errors_occurred <= 8'h00;
        end else begin
            errors_occurred <= errors_occurred | err_occurred_evt;
        end
    end

    // Uptime counts from full reset only
    always_ff @(posedge mclk) begin
        if (rst) begin
            uptime <= 32'h00000000;
        end else begin
            uptime <= uptime + 32'h1;
        end
    end

    // Interrupt events
    assign events[spc_pkg::EV_SOFT_RESET] = soft_rst;
    assign events[spc_pkg::EV_FAULT_CLR] = fault_clear;
    assign events[spc_pkg::EV_PARAM] = cmd.valid && known && !reload
        && cmd.opcode != spc_pkg::OP_CLR_FAULT;
    assign events[spc_pkg::EV_BAD_CMD] = cmd.valid && !known;

    // Sticky status: set wins over write-one-to-clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_stat <= '0;
        end else if (wr && addr == spc_pkg::A_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~wdata[spc_pkg::EV_W-1:0]) | events;
        end else begin
            irq_stat <= irq_stat | events;
        end
    end

    // Control and mask registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl <= spc_pkg::CTRL_RESET;
            irq_mask <= '0;
        end else if (wr) begin
            if (addr == spc_pkg::A_CTRL) begin
                ctrl <= wdata[1:0];
            end
            if (addr == spc_pkg::A_IRQ_MASK) begin
                irq_mask <= wdata[spc_pkg::EV_W-1:0];
            end
        end
    end

    // Interrupt output, registered
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            case (addr)
                spc_pkg::A_CTRL: rdata <= {30'h0, ctrl};
                spc_pkg::A_STATUS: begin
                    rdata <= {26'h0, op_state, safe_start, err_flags};
                end
                spc_pkg::A_IRQ_STAT: rdata <= {28'h0, irq_stat};
                spc_pkg::A_IRQ_MASK: rdata <= {28'h0, irq_mask};
                spc_pkg::A_MAX_SPEED: rdata <= work_params.max_speed;
                spc_pkg::A_START_SPEED: rdata <= work_params.start_speed;
                spc_pkg::A_MAX_ACCEL: rdata <= work_params.max_accel;
                spc_pkg::A_MAX_DECEL: rdata <= work_params.max_decel;
                spc_pkg::A_STEP_MODE: rdata <= {25'h0, work_params.step_mode};
                spc_pkg::A_ERRORS: rdata <= {24'h0, errors_occurred};
                spc_pkg::A_POSITION: rdata <= position;
                default: rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    // Checks
    sequence s_reset_cmd;
        cmd.valid && cmd.opcode == spc_pkg::OP_SOFT_RESET;
    endsequence

    // A cycle with no soft reset; the halt pulse must end after one
    sequence s_no_reset;
        !(cmd.valid && cmd.opcode == spc_pkg::OP_SOFT_RESET);
    endsequence

    a_reload_params: assert property (@(posedge mclk)
        disable iff (rst) s_reset_cmd |=> work_params == $past(nv_params))
        else $error("params not reloaded");
    a_halt_pulse: assert property (@(posedge mclk)
        disable iff (rst) s_reset_cmd |=> motor_halt && driver_reset
            && op_state == spc_pkg::SPC_OP_RESET)
        else $error("no halt on reset");
    a_halt_end: assert property (@(posedge mclk)
        disable iff (rst) s_reset_cmd ##1 s_no_reset
            |=> !motor_halt && !driver_reset
            && op_state == spc_pkg::SPC_OP_RUN)
        else $error("halt held too long");
    a_pos_clear: assert property (@(posedge mclk)
        disable iff (rst) s_reset_cmd |=> position == 0 && enc_position == 0
            && last_move == 0)
        else $error("positions not cleared");
    a_err_clear: assert property (@(posedge mclk)
        disable iff (rst) s_reset_cmd |=> errors_occurred == 0
            && !err_flags[spc_pkg::ERR_SERIAL]
            && !err_flags[spc_pkg::ERR_TIMEOUT])
        else $error("errors not cleared");
    a_safe_entry: assert property (@(posedge mclk)
        disable iff (rst)
        s_reset_cmd |=> safe_start == $past(ctrl[spc_pkg::CTRL_SAFE_EN]))
        else $error("safe start wrong");
    a_deen_keep: assert property (@(posedge mclk)
        disable iff (rst) s_reset_cmd
        and (!fault_set_deenergize && !fault_clr_deenergize)
        |=> $stable(err_flags[spc_pkg::ERR_DEENERGIZED]))
        else $error("de-energised bit changed");
    a_uptime_run: assert property (@(posedge mclk)
        disable iff (rst) s_reset_cmd |=> uptime == $past(uptime) + 32'h1)
        else $error("uptime disturbed");
    a_fault_clr: assert property (@(posedge mclk)
        disable iff (rst) cmd.valid && cmd.opcode == spc_pkg::OP_CLR_FAULT
        |=> fault_clear)
        else $error("fault not cleared");
    a_auto_clr: assert property (@(posedge mclk)
        disable iff (rst) driver_fault && ctrl[spc_pkg::CTRL_AUTO_CLR]
        |=> fault_clear)
        else $error("fault not auto cleared");
    a_speed_cap: assert property (@(posedge mclk)
        disable iff (rst) cmd.valid && cmd.opcode == spc_pkg::OP_MAX_SPEED
        |=> work_params.max_speed <= spc_pkg::SPEED_MAX)
        else $error("speed over cap");
    a_start_cap: assert property (@(posedge mclk)
        disable iff (rst) cmd.valid && cmd.opcode == spc_pkg::OP_START_SPEED
        |=> work_params.start_speed <= spc_pkg::SPEED_MAX)
        else $error("start speed over cap");
    a_accel_floor: assert property (@(posedge mclk)
        disable iff (rst) work_params.max_accel >= spc_pkg::ACCEL_MIN
        || $past(reload) || $past(rst))
        else $error("accel below floor");
    a_decel_keep: assert property (@(posedge mclk)
        disable iff (rst) cmd.valid && cmd.opcode == spc_pkg::OP_MAX_ACCEL
        |=> $stable(work_params.max_decel))
        else $error("decel moved by accel write");
    a_decel_copy: assert property (@(posedge mclk)
        disable iff (rst) cmd.valid && cmd.opcode == spc_pkg::OP_MAX_DECEL
        && cmd.data == 0
        |=> work_params.max_decel == $past(work_params.max_accel))
        else $error("decel not copied");
    a_step_keep: assert property (@(posedge mclk)
        disable iff (rst) cmd.valid && cmd.opcode == spc_pkg::OP_STEP_MODE
        && cmd.data[6:0] > spc_pkg::STEP_MODE_MAX
        |=> $stable(work_params.step_mode))
        else $error("bad step mode taken");

endmodule
`default_nettype wire

// ===== tb/spc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host side of the command link: one decoded command per valid cycle
module spc_host_model #(
    parameter int HOLD_OFF = 50
) (
    input wire logic mclk,
    output var spc_pkg::spc_cmd_t cmd
);
    initial cmd = '0;

    // Opcode and data turn to their inverse once released, never stale
    task automatic send(input logic [7:0] op, input logic [31:0] d);
        @(posedge mclk);
        cmd <= '{valid: 1'b1, opcode: op, data: d};
        @(posedge mclk);
        cmd <= '{valid: 1'b0, opcode: ~op, data: ~d};
        #1;
    endtask

    // Quiet time after a soft reset, scaled down to keep the run short
    task automatic hold_off();
        repeat (HOLD_OFF) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ===== tb/stepper_param_cmd_handler_bench.sv
`timescale 1ns/1ns
`default_nettype none
module stepper_param_cmd_handler_bench;
    localparam spc_pkg::spc_params_t NV = {32'h00010000, 32'h00000200,
        32'h00000300, 32'h00000400, 7'h02};
    logic mclk, rst, drv_fault, dset, e_ser, e_to, pstep, estep, mv_v;
    logic wr, rd, halt, drst, fclr, safe, irq;
    logic [7:0] e_occ, mv, addr, last_move, errs_occ;
    logic [31:0] wdata, rdata, position, enc_position, uptime, d, u0;
    logic [2:0] err_flags;
    spc_pkg::spc_cmd_t cmd;
    spc_pkg::spc_params_t wp;
    spc_pkg::spc_op_t ops;
    int err_count, tests_run;

    spc_host_model host (.mclk(mclk), .cmd(cmd));

    spc_cmd_handler DUT (.mclk(mclk), .rst(rst), .cmd(cmd), .nv_params(NV),
        .driver_fault(drv_fault), .fault_set_deenergize(dset),
        .fault_clr_deenergize(1'b0), .err_serial_evt(e_ser),
        .err_timeout_evt(e_to), .err_occurred_evt(e_occ),
        .pos_step(pstep), .pos_dir(1'b0), .enc_step(estep),
        .enc_dir(1'b0), .move_cmd_valid(mv_v), .move_cmd(mv),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .work_params(wp), .motor_halt(halt), .driver_reset(drst),
        .fault_clear(fclr), .safe_start(safe), .op_state(ops),
        .last_move(last_move), .position(position),
        .enc_position(enc_position), .err_flags(err_flags),
        .errors_occurred(errs_occ), .uptime(uptime), .irq(irq));

    // Free-running 100 MHz clock
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Register port: one-cycle strobes, read data taken the cycle after
    task automatic w(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic r(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk_nv();
        chk(wp.max_speed, NV.max_speed);
        chk(wp.start_speed, NV.start_speed);
        chk(wp.max_accel, NV.max_accel);
        chk(wp.max_decel, NV.max_decel);
        chk({25'h0, wp.step_mode}, {25'h0, NV.step_mode});
    endtask

    // Max speed clamps just past the limit, start speed from all ones; both keep values inside it
    task automatic t_speed();
        host.send(spc_pkg::OP_MAX_SPEED, 32'h1dcd6501);
        chk(wp.max_speed, spc_pkg::SPEED_MAX);
        host.send(spc_pkg::OP_MAX_SPEED, 32'h00abcdef);
        chk(wp.max_speed, 32'h00abcdef);
        r(spc_pkg::A_MAX_SPEED, d);
        chk(d, 32'h00abcdef);
        host.send(spc_pkg::OP_START_SPEED, 32'hffffffff);
        chk(wp.start_speed, spc_pkg::SPEED_MAX);
        host.send(spc_pkg::OP_START_SPEED, 32'h00001234);
        chk(wp.start_speed, 32'h00001234);
    endtask

    // Acceleration floor, deceleration copy and floor, boundary values
    task automatic t_accel();
        host.send(spc_pkg::OP_MAX_DECEL, 32'h00005000);
        chk(wp.max_decel, 32'h00005000);
        host.send(spc_pkg::OP_MAX_ACCEL, 32'h00000063);
        chk(wp.max_accel, 32'h00000064);
        chk(wp.max_decel, 32'h00005000);
        host.send(spc_pkg::OP_MAX_ACCEL, 32'h00000000);
        chk(wp.max_accel, 32'h00000064);
        host.send(spc_pkg::OP_MAX_ACCEL, 32'hffffffff);
        chk(wp.max_accel, spc_pkg::ACCEL_MAX);
        host.send(spc_pkg::OP_MAX_ACCEL, 32'h00003000);
        host.send(spc_pkg::OP_MAX_DECEL, 32'h00000000);
        chk(wp.max_decel, 32'h00003000);
        host.send(spc_pkg::OP_MAX_DECEL, 32'h00000001);
        chk(wp.max_decel, 32'h00000064);
        host.send(spc_pkg::OP_MAX_DECEL, 32'h00000063);
        chk(wp.max_decel, 32'h00000064);
    endtask

    // Every step mode code, then an out-of-range code that must not stick
    task automatic t_step();
        for (int i = 0; i < 6; i++) begin
            host.send(spc_pkg::OP_STEP_MODE, i[31:0]);
            chk({25'h0, wp.step_mode}, i[31:0]);
        end
        host.send(spc_pkg::OP_STEP_MODE, 32'h00000006);
        chk({25'h0, wp.step_mode}, 32'h00000005);
    endtask

    // Soft reset after state and errors have built up
    task automatic t_soft();
        w(spc_pkg::A_CTRL, 32'h00000003);
        @(posedge mclk);
        {e_ser, e_to, dset, pstep, estep, mv_v} <= 6'h3f;
        e_occ <= 8'h5a;
        mv <= 8'h3c;
        @(posedge mclk);
        {e_ser, e_to, dset, pstep, estep, mv_v} <= 6'h00;
        e_occ <= 8'h00;
        cyc(1);
        chk(position, 32'h1);
        chk(enc_position, 32'h1);
        chk({24'h0, last_move}, 32'h3c);
        chk({29'h0, err_flags}, 32'h7);
        chk({24'h0, errs_occ}, 32'h5a);
        u0 = uptime;
        host.send(spc_pkg::OP_SOFT_RESET, 32'h0);
        chk({30'h0, halt, drst}, 32'h3);
        chk({30'h0, ops}, 32'h0);
        chk_nv();
        chk(position | enc_position | {24'h0, last_move}, 32'h0);
        chk({29'h0, err_flags}, 32'h1);
        chk({24'h0, errs_occ}, 32'h0);
        chk({31'h0, safe}, 32'h1);
        chk({31'h0, uptime > u0}, 32'h1);
        cyc(1);
        chk({30'h0, halt, drst}, 32'h0);
        chk({30'h0, ops}, 32'h1);
        host.hold_off();
    endtask

    // Manual fault clearing with auto clear off, then auto clearing
    task automatic t_fault();
        w(spc_pkg::A_CTRL, 32'h00000000);
        @(posedge mclk);
        drv_fault <= 1'b1;
        cyc(2);
        chk({31'h0, fclr}, 32'h0);
        host.send(spc_pkg::OP_CLR_FAULT, 32'h0);
        chk({31'h0, fclr}, 32'h1);
        w(spc_pkg::A_CTRL, 32'h00000001);
        cyc(1);
        chk({31'h0, fclr}, 32'h1);
        @(posedge mclk);
        drv_fault <= 1'b0;
    endtask

    // Interrupt raised, cleared, masked; unknown opcode; unmapped read
    task automatic t_irq();
        w(spc_pkg::A_IRQ_STAT, 32'h0000000f);
        w(spc_pkg::A_IRQ_MASK, 32'h00000004);
        host.send(spc_pkg::OP_MAX_SPEED, 32'h00000100);
        cyc(1);
        chk({31'h0, irq}, 32'h1);
        r(spc_pkg::A_IRQ_STAT, d);
        chk(d, 32'h4);
        w(spc_pkg::A_IRQ_STAT, 32'h00000004);
        cyc(1);
        chk({31'h0, irq}, 32'h0);
        host.send(8'h33, 32'h0);
        r(spc_pkg::A_IRQ_STAT, d);
        chk(d, 32'h8);
        chk({31'h0, irq}, 32'h0);
        r(8'h80, d);
        chk(d, 32'h0);
    endtask

    // Reinitialise drops an override just like a soft reset
    task automatic t_reinit();
        host.send(spc_pkg::OP_MAX_ACCEL, 32'h00007777);
        chk(wp.max_accel, 32'h00007777);
        host.send(spc_pkg::OP_REINIT, 32'h0);
        chk_nv();
    endtask

    initial begin
        {rst, drv_fault, dset, e_ser, e_to, pstep, estep, mv_v} = 8'h80;
        {wr, rd, e_occ, mv, addr, wdata} = '0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        cyc(1);
        chk_nv();
        t_speed();
        t_accel();
        t_step();
        t_soft();
        t_fault();
        t_irq();
        t_reinit();
        report_and_stop();
    end

    // Watchdog well beyond the roughly 135 cycles the tests need
    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
